// ===== core/fbn_pkg.sv
/*
 * Shared constants and types of the fieldbus node configuration and status block.
 * Assumes a single 20 MHz system clock and word-aligned Avalon-MM register access.
 */
//
// Behaviour
// - Switches 0..63 form node address directly
// - Address above 63 uses stored command value
// - Network may write pending node address
// - Written address applies after save and restart
// - Rate switch 0,1,2 selects 125/250/500 kbit/s
// - Rate switch above 2 uses stored rate
// - Network rate write 0..2, applies after save/restart
// - Indicator dark while node not online and no fault present
// - Steady green when online, connected, allocated, configured
// - Blinking green when online but not fully configured
// - Blinking red on recoverable error or waiting
// - Steady red on unrecoverable fault, duplicate address or bus-off
package fbn_pkg;

////////////////////////////////////////////////////////////////////////////////

	// Register byte offsets
	localparam logic [4:0] OFS_STATUS = 5'h00;
	localparam logic [4:0] OFS_ADDR_CFG = 5'h04;
	localparam logic [4:0] OFS_RATE_CFG = 5'h08;
	localparam logic [4:0] OFS_COMMAND = 5'h0C;
	localparam logic [4:0] OFS_SWITCH = 5'h10;

	// Field positions
	localparam int STAT_ADDR_LSB = 0;
	localparam int STAT_RATE_LSB = 8;
	localparam int STAT_ADDR_SW_BIT = 12;
	localparam int STAT_RATE_SW_BIT = 13;
	localparam int STAT_LED_LSB = 16;
	localparam int CFG_PEND_LSB = 0;
	localparam int CFG_STORED_LSB = 8;
	localparam int CMD_SAVE_BIT = 0;
	localparam int CMD_RESTART_BIT = 1;
	localparam int SW_TENS_LSB = 0;
	localparam int SW_UNITS_LSB = 4;
	localparam int SW_RATE_LSB = 8;

	// Reset values of pending and stored settings
	localparam logic [5:0] RST_NODE_ADDR = 6'h3F;
	localparam logic [1:0] RST_RATE = 2'h0;

	// Switch ranges
	localparam logic [3:0] DIGIT_MAX = 4'h9;
	localparam logic [7:0] ADDR_MAX = 8'h3F;
	localparam logic [3:0] RATE_SW_MAX = 4'h2;
	localparam logic [1:0] RATE_CODE_MAX = 2'h2;
	localparam logic [7:0] TENS_WEIGHT = 8'h0A;

	// Rate codes
	localparam logic [1:0] RATE_125K = 2'h0;
	localparam logic [1:0] RATE_250K = 2'h1;
	localparam logic [1:0] RATE_500K = 2'h2;

	// Timing
	localparam int CLK_HZ = 20_000_000;
	localparam int BLINK_HALF_MS = 500;
	localparam int BLINK_HALF_CYCLES = CLK_HZ / 1000 * BLINK_HALF_MS;
	localparam int BLINK_CNT_W = 24;
	localparam logic [1:0] SETTLE_DONE = 2'h3;

	typedef enum logic [2:0] {
		LED_DARK,
		LED_GREEN,
		LED_GREEN_BLINK,
		LED_RED_BLINK,
		LED_RED
	} fbn_led_e;

endpackage : fbn_pkg

// ===== core/fbn_blink.sv
/*
 * Blink phase generator for the status indicator.
 * Assumes one system clock; the half period is given in clock cycles.
 */
module fbn_blink #(
	parameter int HALF_CYCLES = fbn_pkg::BLINK_HALF_CYCLES
) (
	input wire logic clk_sys, // System clock
	input wire logic nrst, // Asynchronous reset, active low
	output logic phase // Blink phase, high in the lit half
);

	typedef struct packed {
		logic [fbn_pkg::BLINK_CNT_W-1:0] count;
		logic phase;
	} fbn_blink_s;

	localparam logic [fbn_pkg::BLINK_CNT_W-1:0] LAST = fbn_pkg::BLINK_CNT_W'(HALF_CYCLES - 1);

	fbn_blink_s st;
	fbn_blink_s next_st;

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		next_st = st;
		if (st.count == LAST) begin
			next_st.count = '0;
			next_st.phase = ~st.phase;
		end else begin
			next_st.count = st.count + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign phase = st.phase;

	////////////////////////////////////////////////////////////////////////////////

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	blink_toggle_a: assert property (st.count == LAST |=> st.phase != $past(st.phase))
		else $error("blink phase did not toggle at end of half period");
	blink_hold_a: assert property (st.count != LAST |=> $stable(st.phase) && st.count == $past(st.count) + 1'b1)
		else $error("blink phase changed inside half period");

endmodule : fbn_blink

// ===== core/fbn_node.sv
/*
 * Fieldbus node configuration selection and combined status indicator.
 * Assumes rotary switches arrive asynchronously on pins, node state flags come
 * from protocol logic on clk_sys, and software uses Avalon-MM with waitrequest.
 */
module fbn_node #(
	parameter int BLINK_HALF = fbn_pkg::BLINK_HALF_CYCLES
) (
	input wire logic clk_sys, // System clock, 20 MHz
	input wire logic nrst, // Asynchronous reset, active low
	// Avalon-MM slave
	input wire logic [4:0] avs_address, // Byte address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [3:0] avs_byteenable, // Byte lanes
	input wire logic [31:0] avs_writedata, // Write data
	output logic [31:0] avs_readdata, // Read data
	output logic avs_waitrequest, // Stall, high until answer
	// Rotary switch pins
	input wire logic [3:0] address_tens_switch, // Tens digit of address
	input wire logic [3:0] address_units_switch, // Units digit of address
	input wire logic [3:0] bit_rate_switch, // Bit-rate position
	// Node state from protocol logic
	input wire logic node_online, // Node is online
	input wire logic duplicate_node_address_check, // Duplicate check passed
	input wire logic conn_established, // Connections established
	input wire logic master_allocated, // Allocated to a master
	input wire logic config_ok, // Configuration complete and valid
	input wire logic recoverable_error, // Clearable error present
	input wire logic io_conn_waiting, // An I/O connection waits
	input wire logic unrecoverable_error, // Fatal device fault
	input wire logic dup_address_found, // Duplicate address detected
	input wire logic bus_off, // CAN controller bus-off
	// Results
	output logic [5:0] node_address, // Active node address
	output logic [1:0] bit_rate_sel, // Active rate code
	output logic led_green, // Indicator green element
	output logic led_red // Indicator red element
);

	typedef struct packed {
		logic [3:0] sw1_tens;
		logic [3:0] sw1_units;
		logic [3:0] sw1_rate;
		logic [3:0] sw2_tens;
		logic [3:0] sw2_units;
		logic [3:0] sw2_rate;
		logic [1:0] settle;
		logic started;
		logic [5:0] pend_addr;
		logic [1:0] pend_rate;
		logic [5:0] nv_addr;
		logic [1:0] nv_rate;
		logic [5:0] node_address;
		logic [1:0] bit_rate_sel;
		logic addr_from_sw;
		logic rate_from_sw;
		fbn_pkg::fbn_led_e led_state;
		logic led_green;
		logic led_red;
		logic waitrequest;
		logic [31:0] readdata;
	} fbn_node_s;

	fbn_node_s st;
	fbn_node_s next_st;
	logic blink_phase;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [7:0] addr_value(input logic [3:0] tens, input logic [3:0] units);
		addr_value = 8'(tens) * fbn_pkg::TENS_WEIGHT + 8'(units);
	endfunction : addr_value

	function automatic logic addr_valid(input logic [3:0] tens, input logic [3:0] units);
		addr_valid = (tens <= fbn_pkg::DIGIT_MAX) && (units <= fbn_pkg::DIGIT_MAX)
			&& (addr_value(tens, units) <= fbn_pkg::ADDR_MAX);
	endfunction : addr_valid

	function automatic logic rate_valid(input logic [3:0] pos);
		rate_valid = (pos <= fbn_pkg::RATE_SW_MAX);
	endfunction : rate_valid

	function automatic logic at(input logic [4:0] addr, input logic [4:0] ofs);
		at = (addr[4:2] == ofs[4:2]);
	endfunction : at

	////////////////////////////////////////////////////////////////////////////////
	// Blink divider

	fbn_blink #(
		.HALF_CYCLES(BLINK_HALF)
	) u_blink (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.phase(blink_phase)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	logic req;
	logic take;
	logic wr_lo;
	logic do_save;
	logic do_restart;
	logic apply;
	logic hard_fault;
	logic soft_fault;
	logic dark;
	logic all_ready;

	always_comb begin
		next_st = st;
		req = avs_read || avs_write;
		// Request takes effect on the edge where waitrequest is sampled low
		take = req && !st.waitrequest;
		wr_lo = take && avs_write && avs_byteenable[0];
		do_save = wr_lo && at(avs_address, fbn_pkg::OFS_COMMAND) && avs_writedata[fbn_pkg::CMD_SAVE_BIT];
		do_restart = wr_lo && at(avs_address, fbn_pkg::OFS_COMMAND) && avs_writedata[fbn_pkg::CMD_RESTART_BIT];

		// Switch synchronisers
		next_st.sw1_tens = address_tens_switch;
		next_st.sw1_units = address_units_switch;
		next_st.sw1_rate = bit_rate_switch;
		next_st.sw2_tens = st.sw1_tens;
		next_st.sw2_units = st.sw1_units;
		next_st.sw2_rate = st.sw1_rate;
		if (st.settle != fbn_pkg::SETTLE_DONE) begin
			next_st.settle = st.settle + 1'b1;
		end

		// Pending settings from network address and rate writes
		if (wr_lo && at(avs_address, fbn_pkg::OFS_ADDR_CFG) && avs_writedata[7:6] == 2'h0) begin
			next_st.pend_addr = avs_writedata[5:0];
		end
		if (wr_lo && at(avs_address, fbn_pkg::OFS_RATE_CFG)
				&& avs_writedata[7:0] <= 8'(fbn_pkg::RATE_CODE_MAX)) begin
			next_st.pend_rate = avs_writedata[1:0];
		end
		// Save copies pending values into non-volatile image
		if (do_save) begin
			next_st.nv_addr = st.pend_addr;
			next_st.nv_rate = st.pend_rate;
		end

		// Restart, or first settle after reset, applies the selection
		apply = do_restart || (st.settle == fbn_pkg::SETTLE_DONE && !st.started);
		if (apply) begin
			next_st.started = 1'b1;
			next_st.addr_from_sw = addr_valid(st.sw2_tens, st.sw2_units);
			if (addr_valid(st.sw2_tens, st.sw2_units)) begin
				next_st.node_address = 6'(addr_value(st.sw2_tens, st.sw2_units));
			end else begin
				next_st.node_address = next_st.nv_addr;
			end
			next_st.rate_from_sw = rate_valid(st.sw2_rate);
			if (rate_valid(st.sw2_rate)) begin
				next_st.bit_rate_sel = st.sw2_rate[1:0];
			end else begin
				next_st.bit_rate_sel = next_st.nv_rate;
			end
		end

		// Indicator selection in priority order
		hard_fault = unrecoverable_error || dup_address_found || bus_off;
		soft_fault = recoverable_error || io_conn_waiting;
		dark = !node_online || !duplicate_node_address_check;
		all_ready = conn_established && master_allocated && config_ok;
		if (hard_fault) begin
			next_st.led_state = fbn_pkg::LED_RED;
		end else if (soft_fault) begin
			next_st.led_state = fbn_pkg::LED_RED_BLINK;
		end else if (dark) begin
			next_st.led_state = fbn_pkg::LED_DARK;
		end else if (!all_ready) begin
			next_st.led_state = fbn_pkg::LED_GREEN_BLINK;
		end else begin
			next_st.led_state = fbn_pkg::LED_GREEN;
		end
		unique case (next_st.led_state)
			fbn_pkg::LED_DARK: begin
				next_st.led_green = 1'b0;
				next_st.led_red = 1'b0;
			end
			fbn_pkg::LED_GREEN: begin
				next_st.led_green = 1'b1;
				next_st.led_red = 1'b0;
			end
			fbn_pkg::LED_GREEN_BLINK: begin
				next_st.led_green = blink_phase;
				next_st.led_red = 1'b0;
			end
			fbn_pkg::LED_RED_BLINK: begin
				next_st.led_green = 1'b0;
				next_st.led_red = blink_phase;
			end
			default: begin
				next_st.led_green = 1'b0;
				next_st.led_red = 1'b1;
			end
		endcase

		// Bus answer: one wait cycle, then data with waitrequest low
		next_st.waitrequest = !(req && st.waitrequest);
		next_st.readdata = '0;
		if (req && st.waitrequest && avs_read) begin
			if (at(avs_address, fbn_pkg::OFS_STATUS)) begin
				next_st.readdata[fbn_pkg::STAT_ADDR_LSB +: 6] = st.node_address;
				next_st.readdata[fbn_pkg::STAT_RATE_LSB +: 2] = st.bit_rate_sel;
				next_st.readdata[fbn_pkg::STAT_ADDR_SW_BIT] = st.addr_from_sw;
				next_st.readdata[fbn_pkg::STAT_RATE_SW_BIT] = st.rate_from_sw;
				next_st.readdata[fbn_pkg::STAT_LED_LSB +: 3] = st.led_state;
			end else if (at(avs_address, fbn_pkg::OFS_ADDR_CFG)) begin
				next_st.readdata[fbn_pkg::CFG_PEND_LSB +: 6] = st.pend_addr;
				next_st.readdata[fbn_pkg::CFG_STORED_LSB +: 6] = st.nv_addr;
			end else if (at(avs_address, fbn_pkg::OFS_RATE_CFG)) begin
				next_st.readdata[fbn_pkg::CFG_PEND_LSB +: 2] = st.pend_rate;
				next_st.readdata[fbn_pkg::CFG_STORED_LSB +: 2] = st.nv_rate;
			end else if (at(avs_address, fbn_pkg::OFS_SWITCH)) begin
				next_st.readdata[fbn_pkg::SW_TENS_LSB +: 4] = st.sw2_tens;
				next_st.readdata[fbn_pkg::SW_UNITS_LSB +: 4] = st.sw2_units;
				next_st.readdata[fbn_pkg::SW_RATE_LSB +: 4] = st.sw2_rate;
			end
		end else if (!st.waitrequest) begin
			next_st.readdata = '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
			st.pend_addr <= fbn_pkg::RST_NODE_ADDR;
			st.nv_addr <= fbn_pkg::RST_NODE_ADDR;
			st.node_address <= fbn_pkg::RST_NODE_ADDR;
			st.pend_rate <= fbn_pkg::RST_RATE;
			st.nv_rate <= fbn_pkg::RST_RATE;
			st.bit_rate_sel <= fbn_pkg::RST_RATE;
			st.led_state <= fbn_pkg::LED_DARK;
			st.waitrequest <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign avs_readdata = st.readdata;
	assign avs_waitrequest = st.waitrequest;
	assign node_address = st.node_address;
	assign bit_rate_sel = st.bit_rate_sel;
	assign led_green = st.led_green;
	assign led_red = st.led_red;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	sequence req_waiting;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence

	sequence ack_then_release;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence

	bus_answer_a: assert property (req_waiting |=> ack_then_release)
		else $error("bus answer not given after one wait cycle");

	red_steady_a: assert property (hard_fault |=> led_red && !led_green)
		else $error("steady red missing on hard fault");

	red_blink_a: assert property (!hard_fault && soft_fault |=> !led_green && led_red == $past(blink_phase))
		else $error("blinking red wrong on recoverable fault");

	dark_led_a: assert property (!hard_fault && !soft_fault && dark |=> !led_green && !led_red)
		else $error("indicator lit while node not online");

	green_blink_a: assert property (!hard_fault && !soft_fault && !dark && !all_ready
		|=> !led_red && led_green == $past(blink_phase))
		else $error("blinking green wrong while not configured");

	green_steady_a: assert property (!hard_fault && !soft_fault && !dark && all_ready |=> led_green && !led_red)
		else $error("steady green missing in normal operation");

	addr_switch_a: assert property (apply && addr_valid(st.sw2_tens, st.sw2_units)
		|=> node_address == $past(addr_value(st.sw2_tens, st.sw2_units)) && st.addr_from_sw)
		else $error("node address not taken from switches");

	addr_stored_a: assert property (apply && !addr_valid(st.sw2_tens, st.sw2_units)
		|=> node_address == st.nv_addr && !st.addr_from_sw)
		else $error("node address not taken from stored value");

	addr_hold_a: assert property (!apply |=> $stable(node_address) && $stable(bit_rate_sel))
		else $error("active selection changed without restart");

	rate_switch_a: assert property (apply && rate_valid(st.sw2_rate) |=> bit_rate_sel == $past(st.sw2_rate[1:0]))
		else $error("bit rate not taken from switch");

	rate_stored_a: assert property (apply && !rate_valid(st.sw2_rate) |=> bit_rate_sel == st.nv_rate)
		else $error("bit rate not taken from stored value");

	rate_range_a: assert property (wr_lo && at(avs_address, fbn_pkg::OFS_RATE_CFG)
		&& avs_writedata[7:0] > 8'(fbn_pkg::RATE_CODE_MAX) |=> $stable(st.pend_rate))
		else $error("out of range rate code accepted");

endmodule : fbn_node

// ===== bench/fbn_net_model.sv
/*
 * Model of the protocol side that reports the node state to the block.
 * Assumes the bench picks the state; flags change one edge after the request, like logic on clk_sys.
 */
module fbn_net_model (
	input wire logic clk_sys, // System clock
	input wire logic nrst, // Reset, active low
	input wire logic [9:0] state_req, // Requested node state
	output logic node_online, // Online
	output logic duplicate_node_address_check, // Duplicate check passed
	output logic conn_established, // Connections up
	output logic master_allocated, // Master allocation
	output logic config_ok, // Configuration valid
	output logic recoverable_error, // Clearable error
	output logic io_conn_waiting, // I/O connection waits
	output logic unrecoverable_error, // Fatal fault
	output logic dup_address_found, // Duplicate address seen
	output logic bus_off // Bus-off
);
	timeunit 1ns;
	timeprecision 1ns;

////////////////////////////////////////////////////////////////////////////////

	logic [9:0] st;

	// Not online until a state is requested
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st <= 10'h000;
		end else begin
			st <= state_req;
		end
	end

	assign {bus_off, dup_address_found, unrecoverable_error, io_conn_waiting, recoverable_error} = st[9:5];
	assign {config_ok, master_allocated, conn_established, duplicate_node_address_check, node_online} = st[4:0];
endmodule : fbn_net_model

// ===== bench/fbn_node_tb.sv
/*
 * Self-checking bench of the node configuration and status block, with a reference model.
 * Assumes the network state model beside it and a short blink half period.
 */
module fbn_node_tb;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int HALF = 8;
	localparam logic [11:0] SWC [5] = '{12'h036, 12'h246, 12'h3A0, 12'hF99, 12'h000};
	localparam logic [9:0] LEDV [7] = '{10'h000, 10'h01F, 10'h00B, 10'h05F, 10'h29F, 10'h101, 10'h013};
	localparam logic [16:0] OPS [15] = '{{5'h04, 4'hF, 8'h05}, {5'h04, 4'hF, 8'h45}, {5'h08, 4'hF, 8'h03},
		{5'h08, 4'hF, 8'h02}, {5'h08, 4'hE, 8'h01}, {5'h0C, 4'hF, 8'h02}, {5'h0C, 4'hF, 8'h01},
		{5'h0C, 4'hF, 8'h02}, {5'h04, 4'hF, 8'h21}, {5'h08, 4'hF, 8'h01}, {5'h0C, 4'hF, 8'h03},
		{5'h10, 4'hF, 8'hFF}, {5'h00, 4'hF, 8'hFF}, {5'h14, 4'hF, 8'h01}, {5'h04, 4'h0, 8'h07}};

	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [3:0] sw_t = 4'h1;
	logic [3:0] sw_u = 4'h0;
	logic [3:0] sw_r = 4'h1;
	logic [9:0] state_req = 10'h000;
	wire logic [9:0] fl;
	logic [5:0] node_address;
	logic [1:0] bit_rate_sel;
	logic led_green;
	logic led_red;
	logic [31:0] seed = 32'h000075D9;
	logic [31:0] rd;
	int n_mismatch = 0;
	int num_checks = 0;
	int cyc = 0;
	int m_pa = 63, m_pr = 0, m_sa = 63, m_sr = 0, m_ca = 63, m_cr = 0, m_as = 0, m_rs = 0;

	always #25 clk_sys = ~clk_sys;

	fbn_net_model NET (.clk_sys(clk_sys), .nrst(nrst), .state_req(state_req), .node_online(fl[0]),
		.duplicate_node_address_check(fl[1]), .conn_established(fl[2]), .master_allocated(fl[3]),
		.config_ok(fl[4]), .recoverable_error(fl[5]), .io_conn_waiting(fl[6]), .unrecoverable_error(fl[7]),
		.dup_address_found(fl[8]), .bus_off(fl[9]));

	fbn_node #(.BLINK_HALF(HALF)) DUT (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.address_tens_switch(sw_t), .address_units_switch(sw_u), .bit_rate_switch(sw_r),
		.node_online(fl[0]), .duplicate_node_address_check(fl[1]), .conn_established(fl[2]),
		.master_allocated(fl[3]), .config_ok(fl[4]), .recoverable_error(fl[5]), .io_conn_waiting(fl[6]),
		.unrecoverable_error(fl[7]), .dup_address_found(fl[8]), .bus_off(fl[9]),
		.node_address(node_address), .bit_rate_sel(bit_rate_sel), .led_green(led_green), .led_red(led_red));

////////////////////////////////////////////////////////////////////////////////

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	function automatic int exp_led(input logic [9:0] f);
		if (f[9:7] != 3'h0) return 4;
		if (f[6:5] != 2'h0) return 3;
		if (!(f[0] && f[1])) return 0;
		if (!(f[2] && f[3] && f[4])) return 2;
		return 1;
	endfunction : exp_led

	task m_apply();
		m_as = (sw_t <= 9 && sw_u <= 9 && sw_t * 10 + sw_u <= 63);
		m_ca = m_as ? sw_t * 10 + sw_u : m_sa;
		m_rs = (sw_r <= 2);
		m_cr = m_rs ? sw_r : m_sr;
	endtask : m_apply

	function automatic logic [31:0] exp_rd(input logic [4:0] a);
		case (a)
			fbn_pkg::OFS_STATUS: return m_ca | m_cr << 8 | m_as << 12 | m_rs << 13 | exp_led(fl) << 16;
			fbn_pkg::OFS_ADDR_CFG: return m_pa | m_sa << 8;
			fbn_pkg::OFS_RATE_CFG: return m_pr | m_sr << 8;
			fbn_pkg::OFS_SWITCH: return sw_t | sw_u << 4 | sw_r << 8;
			default: return 32'h00000000;
		endcase
	endfunction : exp_rd

	task chk_reg(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk_reg

	task chk_sel();
		@(posedge clk_sys);
		chk_reg({bit_rate_sel, node_address}, {2'(m_cr), 6'(m_ca)});
	endtask : chk_sel

	task chk_led(input int code);
		logic [4:0] g, r;
		g = 5'h00;
		r = 5'h00;
		repeat (2 * HALF) begin
			@(posedge clk_sys);
			if (led_green === 1'b1) g++;
			if (led_red === 1'b1) r++;
		end
		chk_reg({g, r}, {5'(code == 1 ? 2 * HALF : code == 2 ? HALF : 0), 5'(code == 4 ? 2 * HALF : code == 3 ? HALF : 0)});
	endtask : chk_led

	// Hold the request until waitrequest is sampled low
	task bus_wait();
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
	endtask : bus_wait

	task bus_wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= 1'b1;
		bus_wait();
		avs_write <= 1'b0;
		if (be[0]) begin
			if (a == fbn_pkg::OFS_ADDR_CFG && d[7:6] == 2'h0) m_pa = d[5:0];
			if (a == fbn_pkg::OFS_RATE_CFG && d[7:0] <= 8'h02) m_pr = d[1:0];
			if (a == fbn_pkg::OFS_COMMAND && d[0]) begin
				m_sa = m_pa;
				m_sr = m_pr;
			end
			if (a == fbn_pkg::OFS_COMMAND && d[1]) m_apply();
		end
		@(posedge clk_sys);
	endtask : bus_wr

	task rd_chk(input logic [4:0] a);
		avs_address <= a;
		avs_read <= 1'b1;
		bus_wait();
		rd = avs_readdata;
		avs_read <= 1'b0;
		@(posedge clk_sys);
		chk_reg(rd, exp_rd(a));
	endtask : rd_chk

	task end_sim();
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_sim

////////////////////////////////////////////////////////////////////////////////

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			end_sim();
		end
	end

	initial begin
		logic [11:0] c;
		logic [9:0] v;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (6) @(posedge clk_sys);
		m_apply();
		chk_sel();
		for (int i = 0; i < 6; i++) rd_chk(5'(4 * i));
		// Stored settings only act with switches out of range
		sw_t <= 4'h7;
		sw_r <= 4'h5;
		repeat (4) @(posedge clk_sys);
		for (int i = 0; i < 15; i++) begin
			bus_wr(OPS[i][16:12], 32'(OPS[i][7:0]), OPS[i][11:8]);
			chk_sel();
			rd_chk(fbn_pkg::OFS_ADDR_CFG);
			rd_chk(fbn_pkg::OFS_RATE_CFG);
		end
		for (int i = 0; i < 12; i++) begin
			seed = lfsr(seed);
			c = i < 5 ? SWC[i] : seed[11:0];
			sw_t <= c[3:0];
			sw_u <= c[7:4];
			sw_r <= c[11:8];
			repeat (4) @(posedge clk_sys);
			bus_wr(fbn_pkg::OFS_COMMAND, 32'h00000002, 4'hF);
			chk_sel();
			rd_chk(fbn_pkg::OFS_STATUS);
			rd_chk(fbn_pkg::OFS_SWITCH);
		end
		for (int i = 0; i < 16; i++) begin
			seed = lfsr(seed);
			v = i < 7 ? LEDV[i] : seed[9:0] & seed[19:10];
			state_req <= v;
			repeat (3) @(posedge clk_sys);
			chk_led(exp_led(v));
			rd_chk(fbn_pkg::OFS_STATUS);
		end
		end_sim();
	end
endmodule : fbn_node_tb
